// File: mil_regs.svh
// Register map, field positions, reset values and timing figures of the isolation link block
`ifndef MIL_REGS_SVH
`define MIL_REGS_SVH

// Register offsets (byte addresses)
`define MIL_DRIVE_OFS        8'h0c
`define MIL_CFG_OFS          8'h10

// Pin drive register fields
`define MIL_DRV_POS_SEL_HI   7
`define MIL_DRV_POS_SEL_LO   6
`define MIL_DRV_NEG_SEL_HI   5
`define MIL_DRV_NEG_SEL_LO   4
`define MIL_DRV_FIRST_LVL    3
`define MIL_DRV_SECOND_LVL   2
`define MIL_DRV_DIRECT_EN    1
`define MIL_DRV_IRQ_EN       0
`define MIL_DRV_RESET        32'h00000002

// Link configuration register fields
`define MIL_CFG_SWAP         0
`define MIL_CFG_RESET        32'h00000000

// Timing: system clock, frame rate, link cell time
`define MIL_CLK_HZ           25000000
`define MIL_FRAME_HZ         16000
`define MIL_CELL_NS          320
`define MIL_CLK_NS           40

// Frame content: data sample bits then control bits per frame
`define MIL_SAMPLE_BITS      16
`define MIL_CTRL_BITS        8

// Pulse widths inside one cell, in clock cycles
`define MIL_PWM_ONE          6
`define MIL_PWM_ZERO         2
`define MIL_PWM_IDLE         4

`endif

// File: mil_pkg.sv
// Shared types of the isolation link block
package mil_pkg;
  typedef logic [15:0] mil_sample_t;
  typedef logic [7:0]  mil_ctrl_t;
  typedef logic [31:0] mil_word_t;
  typedef enum logic {
    MIL_PH_ACTIVE,
    MIL_PH_IDLE
  } mil_phase_e;
endpackage

// File: mil_link.sv
// Host-side transformer isolation link controller with AHB registers and DMA FIFOs
//
// Operation
// - One 16-bit sample each way per frame.
// - Eight control bits each way per frame.
// - Eight-word RX and TX FIFOs on DMA.
// - Device drives power and clock onto transformer.
// - Link bits are pulse width modulated.
// - Device encodes and decodes both channels.
// - AHB registers, pin drive at 0x0C.
// - Positive select: X1 float, 00 low, 10 high.
// - Negative select uses the same encoding.
// - Direct enable 0: protocol drives pins.
// - Direct enable 1: pins become GPIOs.
// - Swap bit exchanges the two pins.
// - First level reads positive, or negative swapped.
// - Second level reads negative, or positive swapped.
// - Enable bit gates the flag interrupt.
`include "mil_regs.svh"

module mil_link
  import mil_pkg::*;
#(
  parameter int FIFO_DEPTH = 8,
  parameter int WORD_W     = 32
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // AHB-Lite slave
  input  wire logic              HSEL,
  input  wire logic [31:0]       HADDR,
  input  wire logic [1:0]        HTRANS,
  input  wire logic              HWRITE,
  input  wire logic [2:0]        HSIZE,
  input  wire logic [31:0]       HWDATA,
  input  wire logic              HREADY,
  output logic      [31:0]       HRDATA,
  output logic                   HREADYOUT,
  output logic                   HRESP,
  // DMA transmit stream
  input  wire logic [WORD_W-1:0] dmaTxData,
  input  wire logic              dmaTxValid,
  output logic                   dmaTxReady,
  // DMA receive stream
  output logic      [WORD_W-1:0] dmaRxData,
  output logic                   dmaRxValid,
  input  wire logic              dmaRxReady,
  // Control channel toward the line-side partner
  input  wire logic [7:0]        ctrlTxData,
  input  wire logic              ctrlTxValid,
  output logic                   ctrlTxReady,
  output logic      [7:0]        ctrlRxData,
  output logic                   ctrlRxValid,
  // Transformer pins, return data and interrupt
  input  wire logic              powerClockPosIn,
  output logic                   powerClockPosOut,
  output logic                   powerClockPosOe,
  input  wire logic              powerClockNegIn,
  output logic                   powerClockNegOut,
  output logic                   powerClockNegOe,
  input  wire logic              lineRxPin,
  input  wire logic              monitoredStatusFlag,
  output logic                   irq
);

  localparam int PW         = $clog2(FIFO_DEPTH);
  localparam int CELL_CYC   = `MIL_CELL_NS / `MIL_CLK_NS;
  localparam int FRAME_CYC  = `MIL_CLK_HZ / `MIL_FRAME_HZ;
  localparam int FRAME_BITS = `MIL_SAMPLE_BITS + `MIL_CTRL_BITS;

  // Depth must be a power of two, a word two samples, a frame longer than its cells
  if (FIFO_DEPTH < 2 || (1 << PW) != FIFO_DEPTH || WORD_W != 2 * `MIL_SAMPLE_BITS
      || FRAME_CYC < CELL_CYC * (FRAME_BITS + 1)) begin : g_bad_params
    $error("Parameters outside what the link logic can serve");
  end

  // Pin value decode for one select field
  function automatic logic [1:0] pinDrive(input logic [1:0] sel);
    pinDrive = {~sel[0], sel[1]};  // {enable, level}
  endfunction

  // ---------------- Register file and AHB slave ----------------
  logic [1:0]  posSel_reg, posSel_next, negSel_reg, negSel_next;
  logic        directEn_reg, directEn_next, irqEn_reg, irqEn_next;
  logic        swap_reg, swap_next;
  logic        wrPend_reg, wrPend_next;
  logic [7:0]  wrAddr_reg, wrAddr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        irq_reg, irq_next;
  logic        posMeta, posSync, negMeta, negSync, rxMeta, rxSync;
  logic        firstLevel, secondLevel, addrPhase;

  assign firstLevel  = swap_reg ? negSync : posSync;
  assign secondLevel = swap_reg ? posSync : negSync;
  assign addrPhase   = HSEL && HREADY && HTRANS[1];

  always_comb begin
    posSel_next   = posSel_reg;
    negSel_next   = negSel_reg;
    directEn_next = directEn_reg;
    irqEn_next    = irqEn_reg;
    swap_next     = swap_reg;
    wrPend_next   = addrPhase && HWRITE;
    wrAddr_next   = addrPhase ? {HADDR[7:2], 2'b00} : wrAddr_reg;
    rdata_next    = 32'h00000000;
    if (wrPend_reg) begin
      unique case (wrAddr_reg)
        `MIL_DRIVE_OFS: begin
          posSel_next   = HWDATA[`MIL_DRV_POS_SEL_HI:`MIL_DRV_POS_SEL_LO];
          negSel_next   = HWDATA[`MIL_DRV_NEG_SEL_HI:`MIL_DRV_NEG_SEL_LO];
          directEn_next = HWDATA[`MIL_DRV_DIRECT_EN];
          irqEn_next    = HWDATA[`MIL_DRV_IRQ_EN];
        end
        `MIL_CFG_OFS: begin
          swap_next = HWDATA[`MIL_CFG_SWAP];
        end
        default: begin
        end
      endcase
    end
    if (addrPhase && !HWRITE) begin
      unique case ({HADDR[7:2], 2'b00})
        `MIL_DRIVE_OFS: begin
          rdata_next[`MIL_DRV_POS_SEL_HI:`MIL_DRV_POS_SEL_LO] = posSel_next;
          rdata_next[`MIL_DRV_NEG_SEL_HI:`MIL_DRV_NEG_SEL_LO] = negSel_next;
          rdata_next[`MIL_DRV_FIRST_LVL]  = firstLevel;
          rdata_next[`MIL_DRV_SECOND_LVL] = secondLevel;
          rdata_next[`MIL_DRV_DIRECT_EN]  = directEn_next;
          rdata_next[`MIL_DRV_IRQ_EN]     = irqEn_next;
        end
        `MIL_CFG_OFS: rdata_next[`MIL_CFG_SWAP] = swap_next;
        default:      rdata_next = 32'h00000000;
      endcase
    end
    // Interrupt is a registered level, one cycle behind its cause
    irq_next = monitoredStatusFlag && irqEn_reg;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      posSel_reg   <= 2'(`MIL_DRV_RESET >> `MIL_DRV_POS_SEL_LO);
      negSel_reg   <= 2'(`MIL_DRV_RESET >> `MIL_DRV_NEG_SEL_LO);
      directEn_reg <= 1'(`MIL_DRV_RESET >> `MIL_DRV_DIRECT_EN);
      irqEn_reg    <= 1'(`MIL_DRV_RESET >> `MIL_DRV_IRQ_EN);
      swap_reg     <= 1'(`MIL_CFG_RESET >> `MIL_CFG_SWAP);
      wrPend_reg   <= 1'b0;
      wrAddr_reg   <= 8'h00;
      rdata_reg    <= 32'h00000000;
      irq_reg      <= 1'b0;
    end else begin
      posSel_reg   <= posSel_next;
      negSel_reg   <= negSel_next;
      directEn_reg <= directEn_next;
      irqEn_reg    <= irqEn_next;
      swap_reg     <= swap_next;
      wrPend_reg   <= wrPend_next;
      wrAddr_reg   <= wrAddr_next;
      rdata_reg    <= rdata_next;
      irq_reg      <= irq_next;
    end
  end

  assign HRDATA    = rdata_reg;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign irq       = irq_reg;

  // Pin and return-line synchronisers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {posMeta, posSync, negMeta, negSync, rxMeta, rxSync} <= 6'h00;
    end else begin
      posMeta <= powerClockPosIn;
      posSync <= posMeta;
      negMeta <= powerClockNegIn;
      negSync <= negMeta;
      rxMeta  <= lineRxPin;
      rxSync  <= rxMeta;
    end
  end

  // ---------------- FIFOs ----------------
  mil_word_t   txMem_reg [FIFO_DEPTH], txMem_next [FIFO_DEPTH];
  mil_word_t   rxMem_reg [FIFO_DEPTH], rxMem_next [FIFO_DEPTH];
  logic [PW:0] txCnt_reg, txCnt_next, rxCnt_reg, rxCnt_next;
  logic [PW-1:0] txWr_reg, txWr_next, txRd_reg, txRd_next;
  logic [PW-1:0] rxWr_reg, rxWr_next, rxRd_reg, rxRd_next;
  logic        txPush, txPop, rxPush, rxPop;
  mil_word_t   rxPushWord;

  assign dmaTxReady = txCnt_reg != FIFO_DEPTH[PW:0];
  assign dmaRxValid = rxCnt_reg != '0;
  assign dmaRxData  = rxMem_reg[rxRd_reg];
  assign txPush     = dmaTxValid && dmaTxReady;
  assign rxPop      = dmaRxValid && dmaRxReady;

  always_comb begin
    txMem_next = txMem_reg;
    rxMem_next = rxMem_reg;
    txWr_next  = txWr_reg + PW'(txPush);
    txRd_next  = txRd_reg + PW'(txPop);
    rxWr_next  = rxWr_reg + PW'(rxPush);
    rxRd_next  = rxRd_reg + PW'(rxPop);
    txCnt_next = txCnt_reg + (PW+1)'(txPush) - (PW+1)'(txPop);
    rxCnt_next = rxCnt_reg + (PW+1)'(rxPush) - (PW+1)'(rxPop);
    if (txPush)
      txMem_next[txWr_reg] = dmaTxData;
    if (rxPush)
      rxMem_next[rxWr_reg] = rxPushWord;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        txMem_reg[i] <= 32'h00000000;
        rxMem_reg[i] <= 32'h00000000;
      end
      txWr_reg  <= '0;
      txRd_reg  <= '0;
      rxWr_reg  <= '0;
      rxRd_reg  <= '0;
      txCnt_reg <= '0;
      rxCnt_reg <= '0;
    end else begin
      txMem_reg <= txMem_next;
      rxMem_reg <= rxMem_next;
      txWr_reg  <= txWr_next;
      txRd_reg  <= txRd_next;
      rxWr_reg  <= rxWr_next;
      rxRd_reg  <= rxRd_next;
      txCnt_reg <= txCnt_next;
      rxCnt_reg <= rxCnt_next;
    end
  end

  // ---------------- Link framing and PWM ----------------
  logic [10:0] frameCnt_reg, frameCnt_next;
  logic [2:0]  phase_reg, phase_next;
  logic [4:0]  cellNo_reg, cellNo_next;
  logic [2:0]  highCnt_reg, highCnt_next;
  logic [FRAME_BITS-1:0] txShift_reg, txShift_next, rxShift_reg, rxShift_next;
  logic        txHalf_reg, txHalf_next, rxHalf_reg, rxHalf_next;
  mil_sample_t rxLow_reg, rxLow_next;
  mil_ctrl_t   ctrlRx_reg, ctrlRx_next;
  logic        ctrlRxValid_reg, ctrlRxValid_next, pwm_reg, pwm_next;
  mil_phase_e  mode;
  logic        frameStart, cellEnd, rxBit, txEmpty;
  mil_sample_t txSample;
  logic [2:0]  width;
  logic [3:0]  highTotal;

  assign frameStart  = frameCnt_reg == '0;
  assign cellEnd     = phase_reg == 3'(CELL_CYC - 1);
  assign mode        = (cellNo_reg < 5'(FRAME_BITS)) ? MIL_PH_ACTIVE : MIL_PH_IDLE;
  assign txEmpty     = txCnt_reg == '0;
  assign txSample    = txHalf_reg ? txMem_reg[txRd_reg][31:16] : txMem_reg[txRd_reg][15:0];
  assign txPop       = frameStart && !txEmpty && txHalf_reg;
  assign ctrlTxReady = frameStart;  // Byte sampled at frame start
  assign highTotal   = {1'b0, highCnt_reg} + {3'b000, rxSync};
  assign rxBit       = highTotal > 4'(CELL_CYC / 2);
  assign rxPush      = mode == MIL_PH_ACTIVE && cellEnd && cellNo_reg == 5'(FRAME_BITS - 1)
                       && rxHalf_reg && rxCnt_reg != FIFO_DEPTH[PW:0];
  assign rxPushWord  = {rxShift_reg[FRAME_BITS-2:`MIL_CTRL_BITS-1], rxLow_reg};

  always_comb begin
    frameCnt_next    = (frameCnt_reg == 11'(FRAME_CYC - 1)) ? '0 : frameCnt_reg + 11'd1;
    phase_next       = cellEnd ? '0 : phase_reg + 3'd1;
    cellNo_next      = (cellEnd && mode == MIL_PH_ACTIVE) ? cellNo_reg + 5'd1 : cellNo_reg;
    highCnt_next     = cellEnd ? '0 : highTotal[2:0];
    txShift_next     = txShift_reg;
    rxShift_next     = rxShift_reg;
    txHalf_next      = txHalf_reg;
    rxHalf_next      = rxHalf_reg;
    rxLow_next       = rxLow_reg;
    ctrlRx_next      = ctrlRx_reg;
    ctrlRxValid_next = 1'b0;
    if (frameStart) begin
      // Underrun sends silence rather than repeating stale samples
      txShift_next = {txEmpty ? 16'h0000 : txSample, ctrlTxValid ? ctrlTxData : 8'h00};
      txHalf_next  = txEmpty ? txHalf_reg : ~txHalf_reg;
      phase_next   = '0;
      cellNo_next  = '0;
      highCnt_next = '0;
    end else if (cellEnd && mode == MIL_PH_ACTIVE) begin
      txShift_next = {txShift_reg[FRAME_BITS-2:0], 1'b0};
      rxShift_next = {rxShift_reg[FRAME_BITS-2:0], rxBit};
      if (cellNo_reg == 5'(FRAME_BITS - 1)) begin
        ctrlRx_next      = {rxShift_reg[`MIL_CTRL_BITS-2:0], rxBit};
        ctrlRxValid_next = 1'b1;
        rxHalf_next      = ~rxHalf_reg;
        if (!rxHalf_reg)
          rxLow_next = rxShift_reg[FRAME_BITS-2:`MIL_CTRL_BITS-1];
      end
    end
    unique case (mode)
      MIL_PH_ACTIVE: width = txShift_next[FRAME_BITS-1] ? 3'(`MIL_PWM_ONE) : 3'(`MIL_PWM_ZERO);
      MIL_PH_IDLE:   width = 3'(`MIL_PWM_IDLE);
    endcase
    // Idle cells keep a square clock so the partner stays powered
    pwm_next = phase_next < width;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      frameCnt_reg    <= '0;
      phase_reg       <= '0;
      cellNo_reg      <= '0;
      highCnt_reg     <= '0;
      txShift_reg     <= '0;
      rxShift_reg     <= '0;
      txHalf_reg      <= 1'b0;
      rxHalf_reg      <= 1'b0;
      rxLow_reg       <= 16'h0000;
      ctrlRx_reg      <= 8'h00;
      ctrlRxValid_reg <= 1'b0;
      pwm_reg         <= 1'b0;
    end else begin
      frameCnt_reg    <= frameCnt_next;
      phase_reg       <= phase_next;
      cellNo_reg      <= cellNo_next;
      highCnt_reg     <= highCnt_next;
      txShift_reg     <= txShift_next;
      rxShift_reg     <= rxShift_next;
      txHalf_reg      <= txHalf_next;
      rxHalf_reg      <= rxHalf_next;
      rxLow_reg       <= rxLow_next;
      ctrlRx_reg      <= ctrlRx_next;
      ctrlRxValid_reg <= ctrlRxValid_next;
      pwm_reg         <= pwm_next;
    end
  end

  assign ctrlRxData  = ctrlRx_reg;
  assign ctrlRxValid = ctrlRxValid_reg;

  // ---------------- Pin drive ----------------
  logic [1:0] posDrv, negDrv;
  logic [1:0] physPosSel, physNegSel;

  assign physPosSel = swap_reg ? negSel_reg : posSel_reg;
  assign physNegSel = swap_reg ? posSel_reg : negSel_reg;
  assign posDrv     = pinDrive(physPosSel);
  assign negDrv     = pinDrive(physNegSel);

  always_comb begin
    if (directEn_reg) begin
      {powerClockPosOe, powerClockPosOut} = posDrv;
      {powerClockNegOe, powerClockNegOut} = negDrv;
    end else begin
      powerClockPosOe  = 1'b1;
      powerClockNegOe  = 1'b1;
      powerClockPosOut = swap_reg ? ~pwm_reg : pwm_reg;
      powerClockNegOut = swap_reg ? pwm_reg : ~pwm_reg;
    end
  end

endmodule

// File: mil_link_props.sv
// Port-level assertions for the isolation link controller
`include "mil_regs.svh"
module mil_link_props (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Register bus
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  // Link, pins and interrupt
  input wire logic        ctrlTxReady,
  input wire logic        powerClockPosOut,
  input wire logic        powerClockPosOe,
  input wire logic        powerClockNegOut,
  input wire logic        powerClockNegOe,
  input wire logic        monitoredStatusFlag,
  input wire logic        irq
);
  localparam int FRAME = `MIL_CLK_HZ / `MIL_FRAME_HZ;
  logic        rd_reg, rd_next, wr_reg, wr_next, swap_reg, swap_next, seen_reg, seen_next, mapped;
  logic [7:0]  addr_reg, addr_next, drv_reg, drv_next;
  logic [11:0] gap_reg, gap_next;
  logic [1:0]  pSel, nSel;
  // Shadow of the writable bits, updated at the end of each write data phase
  always_comb begin
    rd_next = HSEL && HREADY && HTRANS[1] && !HWRITE;
    wr_next = HSEL && HREADY && HTRANS[1] && HWRITE;
    addr_next = (rd_next || wr_next) ? {HADDR[7:2], 2'b00} : addr_reg;
    drv_next = (wr_reg && addr_reg == `MIL_DRIVE_OFS) ? HWDATA[7:0] : drv_reg;
    swap_next = (wr_reg && addr_reg == `MIL_CFG_OFS) ? HWDATA[`MIL_CFG_SWAP] : swap_reg;
    gap_next = ctrlTxReady ? 12'h001 : gap_reg + 12'h001;
    seen_next = seen_reg || ctrlTxReady;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {rd_reg, wr_reg, swap_reg, seen_reg, addr_reg, gap_reg} <= '0;
      drv_reg <= 8'h02;
    end else begin
      {rd_reg, wr_reg, swap_reg, seen_reg} <= {rd_next, wr_next, swap_next, seen_next};
      {addr_reg, drv_reg, gap_reg} <= {addr_next, drv_next, gap_next};
    end
  end
  assign pSel = swap_reg ? drv_reg[5:4] : drv_reg[7:6];
  assign nSel = swap_reg ? drv_reg[7:6] : drv_reg[5:4];
  assign mapped = addr_reg == `MIL_DRIVE_OFS || addr_reg == `MIL_CFG_OFS;

  a_bus_okay: assert property (@(posedge clk_sys) disable iff (rst) HREADYOUT && !HRESP)
    else $error("bus answer not zero-wait okay");
  a_read_drive: assert property (@(posedge clk_sys) disable iff (rst)
    rd_reg && addr_reg == `MIL_DRIVE_OFS |-> HRDATA[31:8] == 24'h0 && {HRDATA[7:4], HRDATA[1:0]} ==
    {drv_reg[7:4], drv_reg[1:0]}) else $error("drive register read wrong");
  a_idle_zero: assert property (@(posedge clk_sys) disable iff (rst) !rd_reg || !mapped |-> HRDATA == 32'h0)
    else $error("read data not zero");
  a_pos_direct: assert property (@(posedge clk_sys) disable iff (rst)
    drv_reg[1] |-> powerClockPosOe == !pSel[0] && (pSel[0] || powerClockPosOut == pSel[1]))
    else $error("positive pin drive wrong");
  a_neg_direct: assert property (@(posedge clk_sys) disable iff (rst)
    drv_reg[1] |-> powerClockNegOe == !nSel[0] && (nSel[0] || powerClockNegOut == nSel[1]))
    else $error("negative pin drive wrong");
  a_proto_drive: assert property (@(posedge clk_sys) disable iff (rst)
    !drv_reg[1] |-> powerClockPosOe && powerClockNegOe && powerClockPosOut != powerClockNegOut)
    else $error("protocol pin drive wrong");
  a_irq_gate: assert property (@(posedge clk_sys) disable iff (rst)
    irq == $past(monitoredStatusFlag && drv_reg[0])) else $error("interrupt level wrong");
  a_frame_rate: assert property (@(posedge clk_sys) disable iff (rst)
    ctrlTxReady && seen_reg |-> gap_reg == 12'(FRAME)) else $error("frame period wrong");
endmodule

bind mil_link mil_link_props u_mil_link_props (.clk_sys, .rst, .HSEL, .HADDR, .HTRANS, .HWRITE, .HWDATA,
  .HREADY, .HRDATA, .HREADYOUT, .HRESP, .ctrlTxReady, .powerClockPosOut, .powerClockPosOe,
  .powerClockNegOut, .powerClockNegOe, .monitoredStatusFlag, .irq);

// File: mil_line_partner.sv
// Line-side partner: takes power and clock off the pins and echoes the link
module mil_line_partner (
  // Clock
  input  wire logic clk_sys,
  // Host pin drive
  input  wire logic posOut,
  input  wire logic posOe,
  input  wire logic negOut,
  input  wire logic negOe,
  // Test controls
  input  wire logic extOn,
  input  wire logic extPos,
  input  wire logic extNeg,
  input  wire logic slow,
  // Resolved wires and return data
  output logic      posWire,
  output logic      negWire,
  output logic      lineRx
);
  logic posLast, negLast, echo;
  // No pull on the winding: a released wire shows no stable level
  assign posWire = posOe ? posOut : extOn ? extPos : ~posLast;
  assign negWire = negOe ? negOut : extOn ? extNeg : ~negLast;
  always_ff @(posedge clk_sys) begin
    posLast <= posWire;
    negLast <= negWire;
    echo <= posWire && !negWire;
  end
  // Returns every received cell with the same pulse width, promptly or one cycle late
  assign lineRx = slow ? echo : posWire && !negWire;
endmodule

// File: mil_link_bench.sv
// Self-checking bench for the isolation link controller
`include "mil_regs.svh"
module mil_link_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 0, rst = 1, HSEL = 0, HWRITE = 0, dmaTxValid = 0, dmaRxReady = 0;
  logic        ctrlTxValid = 0, flag = 0, extOn = 0, extPos = 0, extNeg = 0, slow = 0;
  logic [31:0] HADDR = 0, HWDATA = 0, dmaTxData = 0, HRDATA, dmaRxData, d, w;
  logic [1:0]  HTRANS = 0, ps, ns, pp, np;
  logic [7:0]  ctrlTxData = 0, ctrlRxData, b;
  logic        HREADYOUT, HRESP, dmaTxReady, dmaRxValid, ctrlTxReady, ctrlRxValid, irq, lineRx, hit, ok;
  logic        posOut, posOe, negOut, negOe, posWire, negWire, sw;
  logic [15:0] txq[$], rxq[$];
  logic [7:0]  corner[4] = '{8'h00, 8'hff, 8'h80, 8'h01};
  int          seed = 32'h84d7, mismatches = 0, checks = 0;

  mil_link u_mil_link (.clk_sys(clk_sys), .rst(rst), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'b010), .HWDATA(HWDATA), .HREADY(1'b1), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .dmaTxData(dmaTxData), .dmaTxValid(dmaTxValid),
    .dmaTxReady(dmaTxReady), .dmaRxData(dmaRxData), .dmaRxValid(dmaRxValid), .dmaRxReady(dmaRxReady),
    .ctrlTxData(ctrlTxData), .ctrlTxValid(ctrlTxValid), .ctrlTxReady(ctrlTxReady),
    .ctrlRxData(ctrlRxData), .ctrlRxValid(ctrlRxValid), .powerClockPosIn(posWire),
    .powerClockPosOut(posOut), .powerClockPosOe(posOe), .powerClockNegIn(negWire),
    .powerClockNegOut(negOut), .powerClockNegOe(negOe), .lineRxPin(lineRx),
    .monitoredStatusFlag(flag), .irq(irq));
  mil_line_partner u_mil_line_partner (.clk_sys(clk_sys), .posOut(posOut), .posOe(posOe),
    .negOut(negOut), .negOe(negOe), .extOn(extOn), .extPos(extPos), .extNeg(extNeg), .slow(slow),
    .posWire(posWire), .negWire(negWire), .lineRx(lineRx));

  always #20 clk_sys = ~clk_sys;
  // Receive side stalls at random
  always @(posedge clk_sys) begin
    if (dmaRxValid === 1'b1 && dmaRxReady) begin
      rxq.push_back(dmaRxData[15:0]);
      rxq.push_back(dmaRxData[31:16]);
    end
    dmaRxReady <= #1 1'($random(seed));
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic ahbWr(input logic [7:0] a, input logic [31:0] v);
    {HSEL, HTRANS, HWRITE, HADDR} = {4'b1101, 24'h0, a};
    @(posedge clk_sys);
    #1 {HSEL, HTRANS, HWDATA} = {3'b000, v};
    @(posedge clk_sys);
    #1;
  endtask
  task automatic ahbRd(input logic [7:0] a, output logic [31:0] v);
    {HSEL, HTRANS, HWRITE, HADDR} = {4'b1100, 24'h0, a};
    @(posedge clk_sys);
    #1 {HSEL, HTRANS} = 3'b000;
    v = HRDATA;
  endtask
  // Looks just after each edge, where the received byte pulse has settled
  task automatic frameEnd;
    do begin
      @(posedge clk_sys);
      #1;
    end while (ctrlRxValid !== 1'b1);
  endtask
  function automatic logic lvl(input logic [1:0] sel, input logic ext);
    return sel[0] ? ext : sel[1];
  endfunction
  task automatic results;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #(80000 * 40);
    mismatches++;
    $display("watchdog expired");
    results();
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    #1 rst = 0;
    check("reset pins", {posOe, posOut, negOe, negOut}, 4'b1010);
    ahbRd(`MIL_DRIVE_OFS, d);
    check("drive reset", d, `MIL_DRV_RESET);
    ahbWr(8'h20, 32'hffffffff);
    ahbRd(8'h20, d);
    check("unmapped", d, 0);
    // Every select pair, both swap settings, far side driving released pins
    extOn = 1;
    for (int i = 0; i < 32; i++) begin
      {sw, ns, ps} = i[4:0];
      {extPos, extNeg} = 2'($random(seed));
      pp = sw ? ns : ps;
      np = sw ? ps : ns;
      ahbWr(`MIL_CFG_OFS, sw);
      ahbWr(`MIL_DRIVE_OFS, {ps, ns, 4'b0010});
      repeat (4) @(posedge clk_sys);
      #1 check("pos enable", posOe, !pp[0]);
      ahbRd(`MIL_DRIVE_OFS, d);
      b = {ps, ns, sw ? lvl(np, extNeg) : lvl(pp, extPos), sw ? lvl(pp, extPos) : lvl(np, extNeg), 2'b10};
      check("drive levels", d, b);
    end
    // Interrupt gating by flag and enable
    for (int i = 0; i < 4; i++) begin
      flag = i[0];
      ahbWr(`MIL_DRIVE_OFS, {30'h0, 1'b1, i[1]});
      @(posedge clk_sys);
      #1 check("irq", irq, i[0] & i[1]);
    end
    // Protocol drive with loop-back partner
    extOn = 0;
    ahbWr(`MIL_CFG_OFS, 0);
    ahbWr(`MIL_DRIVE_OFS, 0);
    for (int i = 0; i < 8; i++) begin
      w = i == 0 ? 32'h8001_7ffe : $random(seed);
      txq.push_back(w[15:0]);
      txq.push_back(w[31:16]);
      {dmaTxData, dmaTxValid} = {w, 1'b1};
      // Ready is read between edges, so the word is taken at the next edge
      while (dmaTxReady !== 1'b1) begin
        @(posedge clk_sys);
        #1;
      end
      @(posedge clk_sys);
      #1;
    end
    dmaTxValid = 0;
    check("tx full", dmaTxReady, 0);
    frameEnd();
    for (int f = 0; f < 20; f++) begin
      b = f < 4 ? corner[f] : 8'($random(seed));
      {ctrlTxData, ctrlTxValid, slow, flag} = {b, f != 5, f[0], 1'($random(seed))};
      frameEnd();
      check("ctrl echo", ctrlRxData, f == 5 ? 0 : b);
    end
    hit = 0;
    for (int s = 0; s + 16 <= rxq.size(); s++) begin
      ok = 1;
      for (int k = 0; k < 16; k++) ok &= rxq[s + k] === txq[k];
      hit |= ok;
    end
    check("sample stream", hit, 1);
    check("tx drained", dmaTxReady, 1);
    results();
  end
endmodule
